// ---- design/atec_counter.sv ----
// Trigger, event and stamp counting for one acquisition period.
// Assumes inputs synchronous to CLK_I and a synchronous active-high reset.
`timescale 1ns/1ns
// Notes on behaviour
// RL1: Trigger counter clears when period starts
// RL2: Count every trigger, accepted or rejected
// RL3: Period ends when count equals terminal value
// RL4: Terminal value zero never ends period
// RL5: Non-event triggers still counted, still stop
// RL6: Event counter counts accepted events
// RL7: Event counter clears at restart
// RL8: Event counter wraps at maximum
// RL9: Trigger stamp is trigger total
// RL10: Time stamp counts steps from zero
// RL11: Stamp counter wraps at maximum
// RL12: Stamp only when selected
// RL13: Out-of-range flag from any channel
// RL14: Input-error flag from any channel
// RL15: Busy system rejects new triggers
// RL16: Stamp is two data words
// RL17: Five time resolutions or off
// RL18: Rising edge gives one trigger pulse
// RL19: Host starts and stops the period
module atec_counter #(
   parameter int unsigned CNT_W     = 32,
   parameter int unsigned CHANNELS  = 32,
   parameter int unsigned CYC_100NS = atec_pkg::CYC_100NS,
   parameter int unsigned CYC_1US   = atec_pkg::CYC_1US,
   parameter int unsigned CYC_10US  = atec_pkg::CYC_10US,
   parameter int unsigned CYC_100US = atec_pkg::CYC_100US,
   parameter int unsigned CYC_1MS   = atec_pkg::CYC_1MS
) (
   input  wire logic                 CLK_I,
   input  wire logic                 SYS_RST_I,
   input  wire logic                 START_I,
   input  wire logic                 STOP_I,
   input  wire logic                 TRIG_I,
   input  wire logic [CNT_W-1:0]     END_COUNT_I,
   input  wire logic [2:0]           STAMP_SEL_I,
   input  wire logic                 BUSY_I,
   input  wire logic                 EVENT_DONE_I,
   input  wire logic [CHANNELS-1:0]  CH_OOR_I,
   input  wire logic [CHANNELS-1:0]  CH_ERR_I,
   output logic                      ACQ_ACTIVE_O,
   output logic                      ACQ_END_O,
   output logic                      TRIG_ACCEPT_O,
   output logic [CNT_W-1:0]          TRIG_COUNT_O,
   output logic [CNT_W-1:0]          EVENT_COUNT_O,
   output logic                      STAMP_VALID_O,
   output logic [atec_pkg::WORD_W-1:0] STAMP_HI_O,
   output logic [atec_pkg::WORD_W-1:0] STAMP_LO_O,
   output logic                      EVT_OOR_O,
   output logic                      EVT_ERR_O
);
   typedef enum logic [1:0] {ATEC_IDLE, ATEC_ARMED, ATEC_EVENT} atec_state_t;

   typedef struct packed {
      atec_state_t                  state;
      logic                         trig_d;
      logic [CNT_W-1:0]             trig_cnt;
      logic [CNT_W-1:0]             evt_cnt;
      logic [CNT_W-1:0]             time_cnt;
      logic                         acq_end;
      logic                         accept;
      logic                         stamp_valid;
      logic [atec_pkg::WORD_W-1:0]  stamp_hi;
      logic [atec_pkg::WORD_W-1:0]  stamp_lo;
      logic                         oor;
      logic                         err;
   } atec_st_t;

   atec_st_t          st_reg, st_next;
   logic              trig_pulse;
   logic              step_tick;
   logic              time_mode;
   logic [CNT_W-1:0]  trig_inc;
   logic [CNT_W-1:0]  stamp_val;

   initial begin
      if (CNT_W != atec_pkg::STAMP_WORDS * atec_pkg::WORD_W || CHANNELS < 1)
         $error("atec_counter: CNT_W must fill two stamp words");
   end

   // Single pulse per rising trigger edge
   assign trig_pulse = TRIG_I & ~st_reg.trig_d; // RL18
   assign time_mode  = (STAMP_SEL_I >= atec_pkg::STAMP_T100NS) &&
                       (STAMP_SEL_I <= atec_pkg::STAMP_T1MS); // RL17
   assign trig_inc   = st_reg.trig_cnt + 1'b1;

   // Stamp source selection
   always_comb begin
      if (STAMP_SEL_I == atec_pkg::STAMP_TRIGGER)
         stamp_val = trig_inc; // RL9
      else
         stamp_val = st_reg.time_cnt; // RL10
   end

   atec_step_gen #(
      .CYC_100NS (CYC_100NS),
      .CYC_1US   (CYC_1US),
      .CYC_10US  (CYC_10US),
      .CYC_100US (CYC_100US),
      .CYC_1MS   (CYC_1MS)
   ) u_step (
      .CLK_I     (CLK_I),
      .SYS_RST_I (SYS_RST_I),
      .clear_i   (START_I),
      .sel_i     (STAMP_SEL_I),
      .tick_o    (step_tick)
   );

   // Period control and counting
   always_comb begin
      st_next             = st_reg;
      st_next.trig_d      = TRIG_I;
      st_next.acq_end     = 1'b0;
      st_next.accept      = 1'b0;
      st_next.stamp_valid = 1'b0;
      if (START_I) begin // RL19
         st_next.state    = ATEC_ARMED;
         st_next.trig_cnt = '0; // RL1
         st_next.evt_cnt  = '0; // RL7
         st_next.time_cnt = '0; // RL10
      end else if (st_reg.state != ATEC_IDLE) begin
         if (STOP_I) begin // RL19
            st_next.state   = ATEC_IDLE;
            st_next.acq_end = 1'b1;
         end else begin
            if (time_mode && step_tick)
               st_next.time_cnt = st_reg.time_cnt + 1'b1; // RL11
            if (EVENT_DONE_I && st_reg.state == ATEC_EVENT) begin
               st_next.state   = ATEC_ARMED;
               st_next.evt_cnt = st_reg.evt_cnt + 1'b1; // RL6 RL8
            end
            if (trig_pulse) begin
               st_next.trig_cnt = trig_inc; // RL2 RL5 RL11
               if (st_reg.state == ATEC_ARMED && !BUSY_I) begin // RL15
                  st_next.state  = ATEC_EVENT;
                  st_next.accept = 1'b1;
                  st_next.oor    = |CH_OOR_I; // RL13
                  st_next.err    = |CH_ERR_I; // RL14
                  if (STAMP_SEL_I != atec_pkg::STAMP_OFF) begin // RL12
                     st_next.stamp_valid = 1'b1;
                     st_next.stamp_hi = stamp_val[CNT_W-1 -: atec_pkg::WORD_W]; // RL16
                     st_next.stamp_lo = stamp_val[atec_pkg::WORD_W-1:0]; // RL16
                  end
               end
               if (END_COUNT_I != '0 && trig_inc == END_COUNT_I) begin // RL3 RL4
                  st_next.state   = ATEC_IDLE;
                  st_next.acq_end = 1'b1;
               end
            end
         end
      end
   end

   // State register
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I)
         st_reg <= '{state: ATEC_IDLE, default: '0};
      else
         st_reg <= st_next;
   end

   assign ACQ_ACTIVE_O  = (st_reg.state != ATEC_IDLE);
   assign ACQ_END_O     = st_reg.acq_end;
   assign TRIG_ACCEPT_O = st_reg.accept;
   assign TRIG_COUNT_O  = st_reg.trig_cnt;
   assign EVENT_COUNT_O = st_reg.evt_cnt;
   assign STAMP_VALID_O = st_reg.stamp_valid;
   assign STAMP_HI_O    = st_reg.stamp_hi;
   assign STAMP_LO_O    = st_reg.stamp_lo;
   assign EVT_OOR_O     = st_reg.oor;
   assign EVT_ERR_O     = st_reg.err;
endmodule : atec_counter

// ---- design/atec_pkg.sv ----
// Shared constants for the acquisition trigger and event counter.
// Assumes a 100 MHz system clock; no other dependencies.
package atec_pkg;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // Stamp step times in ns
   localparam int unsigned STEP_100NS_NS = 100;
   localparam int unsigned STEP_1US_NS   = 1000;
   localparam int unsigned STEP_10US_NS  = 10000;
   localparam int unsigned STEP_100US_NS = 100000;
   localparam int unsigned STEP_1MS_NS   = 1000000;
   // Cycles per step, derived from the clock period
   localparam int unsigned CYC_100NS = STEP_100NS_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_1US   = STEP_1US_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_10US  = STEP_10US_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_100US = STEP_100US_NS / CLK_PERIOD_NS;
   localparam int unsigned CYC_1MS   = STEP_1MS_NS / CLK_PERIOD_NS;
   localparam int unsigned PRESC_W   = 17;
   // Stamp selection codes
   localparam logic [2:0] STAMP_OFF      = 3'h0;
   localparam logic [2:0] STAMP_TRIGGER  = 3'h1;
   localparam logic [2:0] STAMP_T100NS   = 3'h2;
   localparam logic [2:0] STAMP_T1US     = 3'h3;
   localparam logic [2:0] STAMP_T10US    = 3'h4;
   localparam logic [2:0] STAMP_T100US   = 3'h5;
   localparam logic [2:0] STAMP_T1MS     = 3'h6;
   // Stamp words
   localparam int unsigned WORD_W        = 16;
   localparam int unsigned STAMP_WORDS   = 2;
endpackage : atec_pkg

// ---- design/atec_step_gen.sv ----
// Time step generator: one-cycle tick at the selected stamp resolution.
// Assumes a single 100 MHz clock and a synchronous active-high reset.
`timescale 1ns/1ns
module atec_step_gen #(
   parameter int unsigned CYC_100NS = atec_pkg::CYC_100NS,
   parameter int unsigned CYC_1US   = atec_pkg::CYC_1US,
   parameter int unsigned CYC_10US  = atec_pkg::CYC_10US,
   parameter int unsigned CYC_100US = atec_pkg::CYC_100US,
   parameter int unsigned CYC_1MS   = atec_pkg::CYC_1MS
) (
   input  wire logic       CLK_I,
   input  wire logic       SYS_RST_I,
   input  wire logic       clear_i,
   input  wire logic [2:0] sel_i,
   output logic            tick_o
);
   typedef struct packed {
      logic [atec_pkg::PRESC_W-1:0] cnt;
      logic                         tick;
   } atec_sg_t;

   atec_sg_t st_reg, st_next;
   logic [atec_pkg::PRESC_W-1:0] limit;

   initial begin
      if (CYC_100NS < 1 || CYC_1MS >= (1 << atec_pkg::PRESC_W))
         $error("atec_step_gen: step counts out of range");
   end

   // Terminal count for the selected resolution
   always_comb begin
      case (sel_i)
         atec_pkg::STAMP_T100NS: limit = atec_pkg::PRESC_W'(CYC_100NS - 1);
         atec_pkg::STAMP_T1US:   limit = atec_pkg::PRESC_W'(CYC_1US - 1);
         atec_pkg::STAMP_T10US:  limit = atec_pkg::PRESC_W'(CYC_10US - 1);
         atec_pkg::STAMP_T100US: limit = atec_pkg::PRESC_W'(CYC_100US - 1);
         atec_pkg::STAMP_T1MS:   limit = atec_pkg::PRESC_W'(CYC_1MS - 1);
         default:                limit = '0;
      endcase
   end

   // Prescaler restarts with the period
   always_comb begin
      st_next      = st_reg;
      st_next.tick = 1'b0;
      if (clear_i) begin
         st_next.cnt = '0; // RL10
      end else if (st_reg.cnt >= limit) begin
         st_next.cnt  = '0;
         st_next.tick = 1'b1; // RL10
      end else begin
         st_next.cnt = st_reg.cnt + 1'b1;
      end
   end

   // State register
   always_ff @(posedge CLK_I) begin
      if (SYS_RST_I)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   assign tick_o = st_reg.tick;
endmodule : atec_step_gen

// ---- test/atec_checker.sv ----
// Port checker for atec_counter.
// Assumes one clock and a synchronous reset; bound to every instance.
`timescale 1ns/1ns
module atec_checker #(parameter int unsigned CNT_W = 32, parameter int unsigned CHANNELS = 32) (
   input wire logic CLK_I, SYS_RST_I, START_I, STOP_I, TRIG_I, BUSY_I,
   input wire logic ACQ_ACTIVE_O, ACQ_END_O, TRIG_ACCEPT_O, STAMP_VALID_O, EVT_OOR_O, EVT_ERR_O,
   input wire logic [CNT_W-1:0] END_COUNT_I, TRIG_COUNT_O,
   input wire logic [2:0] STAMP_SEL_I,
   input wire logic [CHANNELS-1:0] CH_OOR_I, CH_ERR_I,
   input wire logic [15:0] STAMP_HI_O, STAMP_LO_O
);
   default clocking @(posedge CLK_I); endclocking
   default disable iff (SYS_RST_I);
   logic run;
   // Running period with no start or stop
   assign run = ACQ_ACTIVE_O && !START_I && !STOP_I;
   property p_cnt; run && TRIG_I && !$past(TRIG_I) |=> TRIG_COUNT_O == $past(TRIG_COUNT_O) + 1'b1;
   endproperty
   a_cnt: assert property (p_cnt) else $error("trigger not counted");
   property p_hold; run && TRIG_I && $past(TRIG_I) |=> $stable(TRIG_COUNT_O); endproperty
   a_hold: assert property (p_hold) else $error("held trigger counted");
   property p_end; run && TRIG_I && !$past(TRIG_I) && END_COUNT_I != '0
      && TRIG_COUNT_O + 1'b1 == END_COUNT_I |=> ACQ_END_O && !ACQ_ACTIVE_O; endproperty
   a_end: assert property (p_end) else $error("no end at terminal count");
   property p_zero; run && END_COUNT_I == '0 |=> ACQ_ACTIVE_O; endproperty
   a_zero: assert property (p_zero) else $error("period ended with zero end count");
   property p_busy; BUSY_I |=> !TRIG_ACCEPT_O; endproperty
   a_busy: assert property (p_busy) else $error("accepted while busy");
   property p_stamp; TRIG_ACCEPT_O && STAMP_SEL_I == atec_pkg::STAMP_TRIGGER
      |-> STAMP_VALID_O && {STAMP_HI_O, STAMP_LO_O} == TRIG_COUNT_O; endproperty
   a_stamp: assert property (p_stamp) else $error("bad trigger stamp");
   property p_off; STAMP_SEL_I == atec_pkg::STAMP_OFF |=> !STAMP_VALID_O; endproperty
   a_off: assert property (p_off) else $error("stamp while off");
   property p_flag; TRIG_ACCEPT_O |-> EVT_OOR_O == |$past(CH_OOR_I)
      && EVT_ERR_O == |$past(CH_ERR_I); endproperty
   a_flag: assert property (p_flag) else $error("bad event flags");
   c_acc: cover property (TRIG_ACCEPT_O);
   c_end: cover property (ACQ_END_O);
   c_stv: cover property (STAMP_VALID_O);
endmodule : atec_checker
bind atec_counter atec_checker #(.CNT_W(CNT_W), .CHANNELS(CHANNELS)) u_chk (.*);

// ---- test/atec_trig_src.sv ----
// Trigger source model: one pulse of one to four cycles per request.
// Assumes fire_i changes away from the rising edge.
`timescale 1ns/1ns
module atec_trig_src (
   input  wire logic       clk_i,
   input  wire logic       fire_i,
   input  wire logic [1:0] len_i,
   output logic            trig_o
);
   logic [2:0] cnt_reg = 3'h0;
   // Load length, count down through a low gap
   always_ff @(posedge clk_i) begin
      if (cnt_reg != 3'h0) cnt_reg <= cnt_reg - 3'h1;
      else if (fire_i) cnt_reg <= {1'b0, len_i} + 3'h2;
   end
   assign trig_o = cnt_reg > 3'h1;
endmodule : atec_trig_src

// ---- test/atec_counter_tb.sv ----
// Self-checking bench for atec_counter with a trigger source model.
// Assumes shortened step parameters and four channels.
`timescale 1ns/1ns
module atec_counter_tb;
   logic CLK_I = 1'b0, SYS_RST_I = 1'b1, START_I = 1'b0, STOP_I = 1'b0, BUSY_I = 1'b0;
   logic EVENT_DONE_I = 1'b0, fire = 1'b0, acc_seen, sv_seen;
   logic [31:0] END_COUNT_I = 32'h0, n = 32'h0, e = 32'h0;
   logic [2:0] STAMP_SEL_I = 3'h1;
   logic [3:0] CH_OOR_I = 4'h0, CH_ERR_I = 4'h0;
   logic [7:0] lf = 8'h52;
   int n_errors = 0, comparisons = 0;
   wire logic TRIG_I, ACQ_ACTIVE_O, ACQ_END_O, TRIG_ACCEPT_O, STAMP_VALID_O, EVT_OOR_O, EVT_ERR_O;
   wire logic [31:0] TRIG_COUNT_O, EVENT_COUNT_O;
   wire logic [15:0] STAMP_HI_O, STAMP_LO_O;
   atec_counter #(.CHANNELS(4), .CYC_1US(2), .CYC_10US(3), .CYC_100US(4),
      .CYC_1MS(5)) DUT (.*);
   atec_trig_src src (.clk_i(CLK_I), .fire_i(fire), .len_i(lf[1:0]), .trig_o(TRIG_I));
   initial forever #5 CLK_I = ~CLK_I;
   // Catch one-cycle pulses
   always @(negedge CLK_I) begin
      if (TRIG_ACCEPT_O === 1'b1) acc_seen = 1'b1;
      if (STAMP_VALID_O === 1'b1) sv_seen = 1'b1;
   end
   function automatic logic [7:0] rnd();
      lf = {lf[6:0], lf[7] ^ lf[5] ^ lf[4] ^ lf[3]};
      return lf;
   endfunction : rnd
   // Time stamp near 22 cycles over the step length
   function automatic logic stamp_ok(input int s);
      int d;
      int k;
      k = (s == 2) ? atec_pkg::CYC_100NS : s - 1;
      d = int'({STAMP_HI_O, STAMP_LO_O}) - 22 / k;
      return d >= -2 && d <= 2;
   endfunction : stamp_ok
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic tick(input int k); repeat (k) @(negedge CLK_I); endtask : tick
   task automatic pulse(ref logic s); s = 1'b1; tick(1); s = 1'b0; endtask : pulse
   task automatic trig(); acc_seen = 1'b0; sv_seen = 1'b0; pulse(fire); tick(7); endtask : trig
   task automatic wrap_up();
      $display("errors %0d comparisons %0d", n_errors, comparisons);
      if (n_errors == 0 && comparisons > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask : wrap_up
   initial begin #100000; n_errors++; wrap_up(); end
   initial begin
      tick(6); SYS_RST_I = 1'b0;
      pulse(START_I);
      chk(TRIG_COUNT_O, 32'h0);
      for (int i = 0; i < 12; i++) begin
         {CH_OOR_I, CH_ERR_I} = rnd(); BUSY_I = rnd() > 8'hB0; trig(); n++;
         chk(TRIG_COUNT_O, n);
         chk({31'h0, acc_seen}, {31'h0, !BUSY_I});
         if (!BUSY_I) begin
            chk({STAMP_HI_O, STAMP_LO_O}, n);
            chk({30'h0, EVT_OOR_O, EVT_ERR_O}, {30'h0, |CH_OOR_I, |CH_ERR_I});
            pulse(EVENT_DONE_I); tick(1); e++;
         end
         chk(EVENT_COUNT_O, e);
      end
      $display("counting test done");
      END_COUNT_I = 32'h3; BUSY_I = 1'b1; pulse(START_I);
      chk(EVENT_COUNT_O, 32'h0);
      repeat (3) trig();
      chk({31'h0, ACQ_ACTIVE_O}, 32'h0);
      trig(); chk(TRIG_COUNT_O, 32'h3);
      $display("terminal test done");
      END_COUNT_I = 32'h0; BUSY_I = 1'b0;
      for (int s = 0; s < 7; s++) begin
         STAMP_SEL_I = 3'(s); pulse(START_I); tick(20); trig();
         if (s > 1) chk({31'h0, stamp_ok(s)}, 32'h1);
         else chk({31'h0, sv_seen}, {31'h0, s == 1});
         pulse(EVENT_DONE_I);
      end
      chk({31'h0, ACQ_ACTIVE_O}, 32'h1);
      pulse(STOP_I); chk({31'h0, ACQ_ACTIVE_O}, 32'h0);
      $display("stamp test done");
      wrap_up();
   end
endmodule : atec_counter_tb
